// File: verilog/fcr_pkg.sv
// Package of constants and types for the memory control register block.
// Functional notes
// - Writing 1 to run strobe while idle launches selected operation, and is ignored while busy; strobe reads back 0.
// - Bit 7 reads 1 while module idle, 0 while busy.
// - Writing 1 to idle flag with burst enable set enters fast read burst.
// - Divider field bits 5:4 gives module clock: 00 /2, 01 /3, 10 /4, 11 /8.
// - Module clock runs at system clock over two after reset.
// - Burst enable bit 3 selects burst transfers, else single accesses.
// - Select field with run strobe starts protection and latch operations.
// - Select codes: 00 enable, 01 disable, 10 refresh mirror, 11 write mirror.
// - Select must go in the strobe write: the operation comes from that write's select bits, not the stored field.
// - Select field at bits 2:1; burst enable and select read back zero from the control register, but read back in the status register.
`default_nettype none
package fcr_pkg;

  // ********************************
  // Register map and field layout.
  // ********************************
  localparam logic [3:0] CTRL_OFFSET   = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  localparam int         IDLE_BIT      = 7;
  localparam int         RSVD_BIT      = 6;
  localparam int         DIV_HI        = 5;
  localparam int         DIV_LO        = 4;
  localparam int         BURST_BIT     = 3;
  localparam int         SEL_HI        = 2;
  localparam int         SEL_LO        = 1;
  localparam int         RUN_BIT       = 0;
  localparam logic [1:0] DIV_RESET     = 2'h0;
  localparam logic [1:0] SEL_RESET     = 2'h0;

  // ********************************
  // Divider codes and operation timing.
  // ********************************
  localparam logic [1:0] DIV_BY2 = 2'h0;
  localparam logic [1:0] DIV_BY3 = 2'h1;
  localparam logic [1:0] DIV_BY4 = 2'h2;
  localparam logic [1:0] DIV_BY8 = 2'h3;
  localparam logic [2:0] DIV2_LAST = 3'h1;
  localparam logic [2:0] DIV3_LAST = 3'h2;
  localparam logic [2:0] DIV4_LAST = 3'h3;
  localparam logic [2:0] DIV8_LAST = 3'h7;
  localparam logic [3:0] OP_MODULE_TICKS = 4'h8;

  typedef enum logic [1:0] {
    OP_ENABLE_XFER,
    OP_DISABLE_XFER,
    OP_REFRESH_MIRROR,
    OP_WRITE_MIRROR
  } fcr_op_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } fcr_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } fcr_wb_rsp_t;

  typedef struct packed {
    logic    start;
    fcr_op_t op;
  } fcr_cmd_t;

endpackage
`default_nettype wire

// File: verilog/fcr_top.sv
// Control register, operation launcher and clock divider of the memory module.
//
// The Wishbone register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module fcr_top
(
  input  wire logic                 CLK,
  input  wire logic                 RST,
  input  wire fcr_pkg::fcr_wb_req_t WB_REQ,
  output var  fcr_pkg::fcr_wb_rsp_t WB_RSP,
  output var  fcr_pkg::fcr_cmd_t    OP_CMD,
  input  wire logic                 OP_DONE,
  output var  logic                 MOD_CLK_EN,
  output var  logic                 BURST_MODE,
  output var  logic                 FAST_READ_BURST
);
  import fcr_pkg::*;

  // ********************************
  // Bus decode.
  // ********************************
  logic       ack;
  logic [7:0] rdata;
  logic       busy;
  logic [1:0] divider;
  logic [1:0] op_sel;
  logic       burst_en;
  logic       fast_rd;
  logic [2:0] div_cnt;
  logic [3:0] op_ticks;
  logic       op_pend;
  logic       ext_pend;

  logic       access;
  logic       hit_ctrl;
  logic       hit_stat;
  logic       wr_ctrl;
  logic [7:0] wd;
  logic       run_req;
  logic       accepted;
  logic [1:0] next_sel;
  logic [7:0] ctrl_rd;
  logic [7:0] stat_rd;
  logic [7:0] next_rdata;

  assign access     = WB_REQ.cyc && WB_REQ.stb && !ack;
  assign hit_ctrl   = WB_REQ.adr == CTRL_OFFSET;
  assign hit_stat   = WB_REQ.adr == STATUS_OFFSET;
  assign wr_ctrl    = access && WB_REQ.we && WB_REQ.sel[0] && hit_ctrl;
  assign wd         = WB_REQ.dat[7:0];
  assign run_req    = wr_ctrl && wd[RUN_BIT];
  assign accepted   = run_req && !busy;
  assign next_sel   = wd[SEL_HI:SEL_LO];
  assign ctrl_rd    = {!busy, 1'b0, divider, 1'b0, 2'h0, 1'b0};
  assign stat_rd    = {4'h0, fast_rd, burst_en, op_sel};
  assign next_rdata = hit_ctrl ? ctrl_rd : (hit_stat ? stat_rd : 8'h00);

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      ack   <= 1'b0;
      rdata <= 8'h00;
    end
    else
    begin
      ack   <= access;
      rdata <= next_rdata;
    end
  end

  assign WB_RSP = '{ack: ack, dat: {24'h00_0000, rdata}};

  // ********************************
  // Control register fields.
  // ********************************
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      divider  <= DIV_RESET;
      op_sel   <= SEL_RESET;
      burst_en <= 1'b0;
      fast_rd  <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      divider  <= wd[DIV_HI:DIV_LO];
      op_sel   <= next_sel;
      burst_en <= wd[BURST_BIT];
      fast_rd  <= wd[BURST_BIT] ? (fast_rd || wd[IDLE_BIT]) : 1'b0;
    end
  end

  assign BURST_MODE      = burst_en;
  assign FAST_READ_BURST = fast_rd;

  // ********************************
  // Module clock divider.
  // ********************************
  logic [2:0] div_last;
  assign div_last = (divider == DIV_BY2) ? DIV2_LAST :
                    (divider == DIV_BY3) ? DIV3_LAST :
                    (divider == DIV_BY4) ? DIV4_LAST : DIV8_LAST;
  wire div_wrap = div_cnt >= div_last;

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      div_cnt <= 3'h0;
    else
      div_cnt <= div_wrap ? 3'h0 : div_cnt + 3'h1;
  end

  assign MOD_CLK_EN = div_wrap;

  // ********************************
  // Operation launcher and idle tracking.
  // ********************************
  assign busy = op_pend || ext_pend;

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      op_pend  <= 1'b0;
      ext_pend <= 1'b0;
      op_ticks <= 4'h0;
      OP_CMD   <= '0;
    end
    else
    begin
      OP_CMD.start <= accepted;
      if (accepted)
      begin
        OP_CMD.op <= fcr_op_t'(next_sel);
        op_pend   <= 1'b1;
        ext_pend  <= 1'b1;
        op_ticks  <= OP_MODULE_TICKS;
      end
      else
      begin
        if (op_pend && div_wrap)
        begin
          op_ticks <= op_ticks - 4'h1;
          if (op_ticks == 4'h1)
            op_pend <= 1'b0;
        end
        if (OP_DONE)
          ext_pend <= 1'b0;
      end
    end
  end

  // ********************************
  // Checks.
  // ********************************
  a_idle_drops: assert property (@(posedge CLK) disable iff (RST)
    accepted |=> !ctrl_rd[IDLE_BIT])
    else $error("idle not cleared");
  a_busy_until_done: assert property (@(posedge CLK) disable iff (RST)
    ext_pend && !OP_DONE |=> !ctrl_rd[IDLE_BIT])
    else $error("idle before done");
  a_busy_op_time: assert property (@(posedge CLK) disable iff (RST)
    op_pend && !(div_wrap && op_ticks == 4'h1) |=> busy)
    else $error("operation time cut short");
  a_run_reads_zero: assert property (@(posedge CLK) disable iff (RST)
    ack && $past(hit_ctrl) |-> !WB_RSP.dat[RUN_BIT])
    else $error("strobe read nonzero");
  a_start_follows: assert property (@(posedge CLK) disable iff (RST)
    accepted |=> OP_CMD.start && OP_CMD.op == $past(next_sel))
    else $error("no start");
  a_start_pulse: assert property (@(posedge CLK) disable iff (RST)
    OP_CMD.start |=> !OP_CMD.start)
    else $error("start too long");
  a_start_cause: assert property (@(posedge CLK) disable iff (RST)
    OP_CMD.start |-> $past(accepted))
    else $error("start without strobe");
  a_refused_busy: assert property (@(posedge CLK) disable iff (RST)
    run_req && busy |=> !OP_CMD.start)
    else $error("start while busy");
  a_op_held: assert property (@(posedge CLK) disable iff (RST)
    !OP_CMD.start |=> OP_CMD.start || $stable(OP_CMD.op))
    else $error("operation code changed");
  a_sel_stored: assert property (@(posedge CLK) disable iff (RST)
    wr_ctrl |=> op_sel == $past(next_sel))
    else $error("select not stored");
  a_fields_zero: assert property (@(posedge CLK) disable iff (RST)
    ack && $past(hit_ctrl) |-> WB_RSP.dat[3:1] == 3'h0)
    else $error("fields leak");
  a_fast_needs_burst: assert property (@(posedge CLK) disable iff (RST)
    fast_rd |-> burst_en)
    else $error("fast read without burst");
  a_fast_sets: assert property (@(posedge CLK) disable iff (RST)
    wr_ctrl && wd[BURST_BIT] && wd[IDLE_BIT] |=> fast_rd)
    else $error("fast read not entered");
  a_fast_clears: assert property (@(posedge CLK) disable iff (RST)
    wr_ctrl && !wd[BURST_BIT] |=> !fast_rd)
    else $error("fast read not left");
  a_div_stored: assert property (@(posedge CLK) disable iff (RST)
    wr_ctrl |=> divider == $past(wd[DIV_HI:DIV_LO]))
    else $error("divider not stored");
  a_div_by8: assert property (@(posedge CLK) disable iff (RST)
    divider == DIV_BY8 && div_wrap ##1 (divider == DIV_BY8)[*8]
      |-> div_wrap && $past(div_cnt) == DIV8_LAST - 3'h1)
    else $error("divide by eight wrong");
  a_div_by4: assert property (@(posedge CLK) disable iff (RST)
    divider == DIV_BY4 && div_wrap ##1 (divider == DIV_BY4)[*4]
      |-> div_wrap && !$past(div_wrap) && !$past(div_wrap, 2) && !$past(div_wrap, 3))
    else $error("divide by four wrong");
  a_div_by3: assert property (@(posedge CLK) disable iff (RST)
    divider == DIV_BY3 && div_wrap ##1 (divider == DIV_BY3)[*3]
      |-> div_wrap && !$past(div_wrap) && !$past(div_wrap, 2))
    else $error("divide by three wrong");
  a_div_by2: assert property (@(posedge CLK) disable iff (RST)
    divider == DIV_BY2 && div_wrap ##1 (divider == DIV_BY2)[*2]
      |-> div_wrap && !$past(div_wrap))
    else $error("divide by two wrong");
  a_idle_read: assert property (@(posedge CLK) disable iff (RST)
    busy && $stable(busy) && ack && $past(hit_ctrl) |-> !WB_RSP.dat[IDLE_BIT])
    else $error("busy read as idle");
  a_idle_returns: assert property (@(posedge CLK) disable iff (RST)
    ack && $past(hit_ctrl) && !$past(busy) |-> WB_RSP.dat[IDLE_BIT])
    else $error("idle read as busy");
  a_burst_follows: assert property (@(posedge CLK) disable iff (RST)
    wr_ctrl |=> BURST_MODE == $past(wd[BURST_BIT]))
    else $error("burst not stored");
  a_status_burst: assert property (@(posedge CLK) disable iff (RST)
    ack && $past(hit_stat) |-> WB_RSP.dat[2] == $past(burst_en))
    else $error("status burst wrong");

endmodule
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench of the memory control register block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fcr_pkg::*;
  logic        clk         = 1'b0;
  logic        rst         = 1'b1;
  fcr_wb_req_t req         = '0;
  logic        done        = 1'b0;
  fcr_wb_rsp_t rsp;
  fcr_cmd_t    cmd;
  logic        ck_en;
  logic        burst;
  logic        fast;
  logic [31:0] rd;
  fcr_op_t     last_op;
  int          err_count   = 0;
  int          checks_done = 0;
  int          starts      = 0;
  int          pulses      = 0;
  int          s0;
  int          div_n[4]    = '{2, 3, 4, 8};

  always #25 clk = ~clk;

  always @(posedge clk)
  begin
    if (ck_en) pulses <= pulses + 1;
    if (cmd.start) starts <= starts + 1;
    if (cmd.start) last_op <= cmd.op;
  end

  fcr_top u_fcr_top (.CLK(clk), .RST(rst), .WB_REQ(req), .WB_RSP(rsp), .OP_CMD(cmd),
    .OP_DONE(done), .MOD_CLK_EN(ck_en), .BURST_MODE(burst), .FAST_READ_BURST(fast));

  // ********************************
  // Bus cycles and comparisons.
  // ********************************
  task automatic print_verdict();
    $display("Mismatches %0d, comparisons %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic we, input logic [3:0] adr, input logic [7:0] wd);
    int n;
    n = 0;
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h1, dat: {24'h00_0000, wd}};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rsp.ack !== 1'b1 && n < 20);
    if (rsp.ack !== 1'b1) check(n, 0);
    if (rsp.ack !== 1'b1) print_verdict();
    rd = rsp.dat;
    req <= '0;
    @(posedge clk);
  endtask

  task automatic count_clk(input int cyc, input int exp);
    int p0;
    p0 = pulses;
    repeat (cyc) @(posedge clk);
    check(pulses - p0, exp);
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    do
    begin
      bus(1'b0, CTRL_OFFSET, 8'h00);
      k++;
    end
    while (rd[7] !== 1'b1 && k < 50);
    check(rd[7], 1'b1);
    if (k >= 50) print_verdict();
  endtask

  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, CTRL_OFFSET, 8'h00);
    check(rd, 32'h0000_0080);
    count_clk(48, 24);
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, CTRL_OFFSET, 8'(i << 4));
      bus(1'b0, CTRL_OFFSET, 8'h00);
      check(rd, 32'h0000_0080 | 32'(i << 4));
      count_clk(48, 48 / div_n[i]);
    end
    bus(1'b1, CTRL_OFFSET, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      s0 = starts;
      bus(1'b1, CTRL_OFFSET, 8'(i << 1));
      check(starts - s0, 0);
      bus(1'b1, CTRL_OFFSET, 8'((i << 1) | 1));
      check(starts - s0, 1);
      check(last_op, i);
      bus(1'b0, CTRL_OFFSET, 8'h00);
      check(rd, 32'h0000_0000);
      bus(1'b1, CTRL_OFFSET, 8'h07);
      check(starts - s0, 1);
      done <= 1'b1;
      @(posedge clk);
      done <= 1'b0;
      wait_idle();
    end
    bus(1'b1, CTRL_OFFSET, 8'h80);
    check({burst, fast}, 2'b00);
    bus(1'b1, CTRL_OFFSET, 8'h08);
    check({burst, fast}, 2'b10);
    bus(1'b1, CTRL_OFFSET, 8'h88);
    check({burst, fast}, 2'b11);
    bus(1'b1, CTRL_OFFSET, 8'h8e);
    bus(1'b0, STATUS_OFFSET, 8'h00);
    check(rd, 32'h0000_000f);
    bus(1'b0, CTRL_OFFSET, 8'h00);
    check(rd, 32'h0000_0080);
    bus(1'b1, CTRL_OFFSET, 8'h00);
    check({burst, fast}, 2'b00);
    bus(1'b0, 4'h8, 8'h00);
    check(rd, 32'h0000_0000);
    print_verdict();
  end
endmodule
`default_nettype wire
